// File: logic/pwmcc_regs.svh
// Constants of the channel counter: widths, reset values and the one and zero constants.
// Assumes inclusion by bare name from the package and from the modules.
`ifndef PWMCC_REGS_SVH
`define PWMCC_REGS_SVH

`define PWMCC_CNT_W      8
`define PWMCC_CNT_RST    8'h00
`define PWMCC_DUTY_RST   8'hFF
`define PWMCC_PER_RST    8'hFF
`define PWMCC_CNT_ONE    8'h01
`define PWMCC_SEL_W      2
`define PWMCC_PRE_W      8
`define PWMCC_PRE_ONE    8'h01
`define PWMCC_PRE_ZERO   8'h00

`endif

// File: logic/pwmcc_pkg.sv
// Types shared by the channel counter modules.
// Assumes the constants header is on the include path.
`include "pwmcc_regs.svh"

package pwmcc_pkg;
    typedef logic [`PWMCC_CNT_W-1:0] pwmcc_byte_t;
    typedef enum logic {PWMCC_UP, PWMCC_DOWN} pwmcc_dir_e;
endpackage : pwmcc_pkg

// File: logic/pwmcc_tick_gen.sv
// Prescaler that turns the bus clock into one-cycle channel clock ticks.
// Assumes a synchronous select input; select 0 ticks on every bus clock.
`timescale 1ns/1ps
`include "pwmcc_regs.svh"

module pwmcc_tick_gen
    import pwmcc_pkg::*;
(
    input  wire logic                     sys_clk_i,
    input  wire logic                     nrst_i,
    input  wire logic [`PWMCC_SEL_W-1:0]  clk_sel_i,
    output logic                          tick_o
);
    logic [`PWMCC_PRE_W-1:0] pre_r;
    logic [`PWMCC_PRE_W-1:0] limit;

    // Divide by 1, 2, 4 or 8
    always_comb begin
        limit = `PWMCC_PRE_ONE << clk_sel_i;
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pre_r <= `PWMCC_PRE_ZERO;
        end else if (pre_r + `PWMCC_PRE_ONE >= limit) begin
            pre_r <= `PWMCC_PRE_ZERO;
        end else begin
            pre_r <= pre_r + `PWMCC_PRE_ONE;
        end
    end

    assign tick_o = (pre_r + `PWMCC_PRE_ONE >= limit);
endmodule : pwmcc_tick_gen

// File: logic/pwmcc_channel.sv
// One pulse-width channel: counter, active duty and period, output flip-flop.
// Assumes all inputs synchronous to sys_clk_i; counter write is a one-cycle strobe.
//
// Contract
// - Reading the counter never changes the count or the waveform.
// - Any counter write forces the count to zero and the direction to up.
// - A counter write loads buffered duty and period into the active registers at once.
// - A counter write sets the output to the level given by polarity.
// - With the channel disabled the counter holds still on ticks unless the buffered period is zero.
// - On enable the counter resumes from the value it holds.
// - Disabled with a zero period, the counter clears on the next channel tick.
// - A counter write while enabled starts a new period at once at the start level.
// - The counter clears to zero when the effective period ends.
// - Center-align select zero gives left-aligned mode; one still counts up only, with no duty toggle.
// - Left-aligned mode uses an 8-bit up-only counter.
// - In left-aligned mode a duty match toggles the output flip-flop unless the period ends on the same tick.
// - A period match resets counter and output and loads buffered period and duty.
// - The counter runs from zero to period minus one, giving period channel clocks.
`timescale 1ns/1ps
`include "pwmcc_regs.svh"

module pwmcc_channel
    import pwmcc_pkg::*;
(
    input  wire logic                     sys_clk_i,
    input  wire logic                     nrst_i,
    input  wire logic                     channel_enable_bit_i,
    input  wire logic                     center_align_select_bit_i,
    input  wire logic                     polarity_i,
    input  wire logic [`PWMCC_SEL_W-1:0]  clk_sel_i,
    input  wire logic [`PWMCC_CNT_W-1:0]  duty_buf_i,
    input  wire logic [`PWMCC_CNT_W-1:0]  period_buf_i,
    input  wire logic                     cnt_wr_i,
    output logic [`PWMCC_CNT_W-1:0]       channel_count_reg_o,
    output logic [`PWMCC_CNT_W-1:0]       duty_act_o,
    output logic [`PWMCC_CNT_W-1:0]       period_act_o,
    output logic                          count_down_o,
    output logic                          tick_o,
    output logic                          pwm_o
);
    pwmcc_byte_t cnt_r;
    pwmcc_byte_t duty_r;
    pwmcc_byte_t per_r;
    pwmcc_dir_e  dir_r;
    pwmcc_dir_e  dir_nxt;
    logic        out_r;
    logic        tick;
    logic        left_mode;
    logic        per_end;
    logic        duty_hit;
    logic        cnt_last;
    pwmcc_byte_t cnt_nxt;

    pwmcc_tick_gen u_tick (
        .sys_clk_i (sys_clk_i),
        .nrst_i    (nrst_i),
        .clk_sel_i (clk_sel_i),
        .tick_o    (tick)
    );

    // Mode and match decode
    assign left_mode = !center_align_select_bit_i;
    assign cnt_last  = (cnt_r + `PWMCC_CNT_ONE == per_r);
    assign per_end   = (per_r == `PWMCC_CNT_RST) || cnt_last;
    assign duty_hit  = (cnt_r == duty_r);

    // Counter next value
    always_comb begin
        cnt_nxt = cnt_r;
        dir_nxt = dir_r;
        if (cnt_wr_i) begin
            cnt_nxt = `PWMCC_CNT_RST;
            dir_nxt = PWMCC_UP;
        end else if (tick && channel_enable_bit_i) begin
            if (per_end) begin
                cnt_nxt = `PWMCC_CNT_RST;
            end else begin
                cnt_nxt = cnt_r + `PWMCC_CNT_ONE;
            end
            if (left_mode) begin
                dir_nxt = PWMCC_UP;
            end
        end else if (tick && period_buf_i == `PWMCC_CNT_RST) begin
            // Period register written to zero while disabled
            cnt_nxt = `PWMCC_CNT_RST;
        end
    end

    // Counter holds when disabled with a nonzero buffered period; read path has no side effect
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_r <= `PWMCC_CNT_RST;
            dir_r <= PWMCC_UP;
        end else begin
            cnt_r <= cnt_nxt;
            dir_r <= dir_nxt;
        end
    end

    // Active duty and period reload
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            duty_r <= `PWMCC_DUTY_RST;
            per_r  <= `PWMCC_PER_RST;
        end else if (cnt_wr_i) begin
            duty_r <= duty_buf_i;
            per_r  <= period_buf_i;
        end else if (tick && channel_enable_bit_i && per_end) begin
            duty_r <= duty_buf_i;
            per_r  <= period_buf_i;
        end
    end

    // Output flip-flop
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            out_r <= 1'b0;
        end else if (cnt_wr_i) begin
            out_r <= polarity_i;
        end else if (tick && channel_enable_bit_i) begin
            if (per_end) begin
                out_r <= polarity_i;
            end else if (duty_hit && left_mode) begin
                out_r <= !out_r;
            end
        end
    end

    assign channel_count_reg_o = cnt_r;
    assign duty_act_o          = duty_r;
    assign period_act_o        = per_r;
    assign count_down_o        = (dir_r == PWMCC_DOWN);
    assign tick_o              = tick;
    assign pwm_o               = out_r;

    // Assertions
    AST_WR_CLEARS: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        cnt_wr_i |=> (cnt_r == `PWMCC_CNT_RST) && (dir_r == PWMCC_UP))
        else $error("Counter write did not clear count");
    AST_WR_LOADS: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        cnt_wr_i |=> (duty_r == $past(duty_buf_i)) && (per_r == $past(period_buf_i)))
        else $error("Counter write did not load buffers");
    AST_WR_OUT: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        cnt_wr_i |=> (out_r == $past(polarity_i)))
        else $error("Counter write did not set start level");
    AST_HOLD: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (!channel_enable_bit_i && !cnt_wr_i && period_buf_i != `PWMCC_CNT_RST)
        |=> $stable(cnt_r))
        else $error("Counter moved while disabled");
    AST_ZERO_PER: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (!channel_enable_bit_i && !cnt_wr_i && tick && period_buf_i == `PWMCC_CNT_RST)
        |=> cnt_r == `PWMCC_CNT_RST)
        else $error("Zero period did not clear counter");
    AST_ADVANCE: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (channel_enable_bit_i && !cnt_wr_i && tick && !per_end)
        |=> cnt_r == $past(cnt_r) + `PWMCC_CNT_ONE)
        else $error("Counter did not advance on tick");
    AST_NO_TICK: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (!tick && !cnt_wr_i) |=> $stable(cnt_r))
        else $error("Counter moved without tick");
    AST_WRAP: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (channel_enable_bit_i && !cnt_wr_i && tick && cnt_last)
        |=> (cnt_r == `PWMCC_CNT_RST) && (out_r == $past(polarity_i)))
        else $error("Period end did not wrap");
    AST_DUTY: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (channel_enable_bit_i && !cnt_wr_i && tick && left_mode && duty_hit && !per_end)
        |=> out_r != $past(out_r))
        else $error("Duty match did not toggle output");
    AST_UP_ONLY: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        left_mode |-> dir_r == PWMCC_UP)
        else $error("Left mode counting down");
endmodule : pwmcc_channel

// File: sim/pwm_channel_counter_bench.sv
// Self-checking bench for one pulse-width channel counter.
// Assumes the package and constants header are compiled first.
`timescale 1ns/1ps
`include "pwmcc_regs.svh"

module pwm_channel_counter_bench
    import pwmcc_pkg::*;
;
    logic        sys_clk_i;
    logic        nrst_i;
    logic        en;
    logic        ca;
    logic        pol;
    logic        wr;
    logic [1:0]  sel;
    pwmcc_byte_t duty_b;
    pwmcc_byte_t per_b;
    pwmcc_byte_t cnt;
    pwmcc_byte_t duty_a;
    pwmcc_byte_t per_a;
    logic        dn;
    logic        tick;
    logic        pwm;
    int          fail_count = 0;
    int          compares   = 0;
    int          cycles     = 0;
    logic [7:0]  ec [4]     = '{8'h01, 8'h02, 8'h03, 8'h00};
    logic [7:0]  ep [4]     = '{8'h01, 8'h00, 8'h00, 8'h01};

    pwmcc_channel dut (
        .sys_clk_i                 (sys_clk_i),
        .nrst_i                    (nrst_i),
        .channel_enable_bit_i      (en),
        .center_align_select_bit_i (ca),
        .polarity_i                (pol),
        .clk_sel_i                 (sel),
        .duty_buf_i                (duty_b),
        .period_buf_i              (per_b),
        .cnt_wr_i                  (wr),
        .channel_count_reg_o       (cnt),
        .duty_act_o                (duty_a),
        .period_act_o              (per_a),
        .count_down_o              (dn),
        .tick_o                    (tick),
        .pwm_o                     (pwm)
    );

    initial begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : step

    // Counter write strobe; caller stands at a rising edge
    task automatic wr_cnt();
        wr <= 1'b1;
        @(posedge sys_clk_i);
        wr <= 1'b0;
        #1;
    endtask : wr_cnt

    task automatic test_done();
        $display("errors %0d compares %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done

    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            fail_count++;
            test_done();
        end
    end

    initial begin
        nrst_i = 1'b0; en = 1'b0; ca = 1'b0; pol = 1'b1; wr = 1'b0; sel = 2'h0;
        duty_b = 8'h01; per_b = 8'h04;
        step(10);
        chk(cnt, 8'h00, "reset count");
        chk(per_a, 8'hFF, "reset period");
        @(posedge sys_clk_i); nrst_i <= 1'b1;
        @(posedge sys_clk_i); en <= 1'b1;
        wr_cnt();
        chk(cnt, 8'h00, "write clears count");
        chk({7'h00, dn}, 8'h00, "direction up");
        chk(per_a, 8'h04, "period loaded");
        chk(duty_a, 8'h01, "duty loaded");
        chk({7'h00, pwm}, 8'h01, "start level");
        for (int i = 0; i < 4; i++) begin
            step(1);
            chk(cnt, ec[i], "walk count");
            chk({7'h00, pwm}, ep[i], "walk output");
        end
        @(posedge sys_clk_i); en <= 1'b0; per_b <= 8'h06;
        step(5);
        chk(cnt, 8'h01, "held while disabled");
        chk(per_a, 8'h04, "period not yet loaded");
        @(posedge sys_clk_i); en <= 1'b1;
        step(1);
        chk(cnt, 8'h02, "resume count");
        chk({7'h00, pwm}, 8'h00, "resume waveform");
        step(2);
        chk(cnt, 8'h00, "period end clears");
        chk(per_a, 8'h06, "period end loads");
        chk({7'h00, pwm}, 8'h01, "period end level");
        step(2);
        @(posedge sys_clk_i); pol <= 1'b0; duty_b <= 8'h03;
        wr_cnt();
        chk(cnt, 8'h00, "write while enabled");
        chk({7'h00, pwm}, 8'h00, "new period level");
        chk(duty_a, 8'h03, "duty loaded at once");
        step(3);
        chk({7'h00, pwm}, 8'h00, "before duty hit");
        step(1);
        chk({7'h00, pwm}, 8'h01, "duty hit toggles");
        @(posedge sys_clk_i); ca <= 1'b1;
        wr_cnt();
        step(4);
        chk({7'h00, pwm}, 8'h00, "no left toggle when centered");
        @(posedge sys_clk_i); ca <= 1'b0; sel <= 2'h2; per_b <= 8'hFF; duty_b <= 8'hFF;
        wr_cnt();
        step(16);
        chk(cnt, 8'h04, "prescaled ticks");
        chk({7'h00, tick}, 8'h00, "no tick between");
        step(2);
        chk({7'h00, tick}, 8'h01, "tick on fourth clock");
        @(posedge sys_clk_i); en <= 1'b0; per_b <= 8'h00;
        step(3);
        chk(cnt, 8'h05, "held before channel tick");
        step(1);
        chk(cnt, 8'h00, "zero period clears on tick");
        test_done();
    end
endmodule : pwm_channel_counter_bench
